/* File: hdl/clock_gen_config_regs.sv */
// configuration register slice of a quad-pll clock generator
//
// Behaviour
// - The low four bits of the pll enable register are active-low enables for plls a, b, c, d in bit order 0 to 3.
// - Bit 7 of the pin control register makes the first multipurpose pin an input at 0 and an output at 1.
// - Bits 6:4 pick the first pin's source: zero, any clock or pll lock loss, pll lock loss, clock loss, monitor status, or debug.
// - Bit 3 of the pin control register makes the second multipurpose pin an input at 0 and an output at 1.
// - Bits 2:0 pick the second pin's source, where the pll group also takes in holdover freeze, and 110 gives no debug.
// - Spare bit 7 at one makes the pad ring supply follow the io supply select and fixes the rail; at zero the rail switch is enabled.
// - Spare bits 5:4 choose the frequency adjust function: digital oscillator, large or small output divider change.
// - Spare bits 3:0 pick one-hot the pll, a to d, that frequency adjust works on.
// - The fuse pointer is a one-hot byte whose bits 7 to 0 point to pages 1, 2, 3, 4, a, b, c, d.
// - Io supply select bit 7 takes the io supply from the input supply at one and from the core supply at zero.
`timescale 1ns/1ps
`include "clock_gen_cfg.svh"

module clock_gen_config_regs import clock_gen_pkg::*; #(
	parameter int NUM_PLL = 4,
	parameter int DEBUG_W = 3
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire reg_req_t reg_req_in,
	input wire notify_src_t notify_in,
	input wire logic pin_a_in,
	input wire logic pin_b_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rdata_valid_out,
	output logic [3:0] pll_enable_n_out,
	output logic pin_a_out,
	output logic pin_a_oe_n_out,
	output logic pin_a_level_out,
	output logic pin_b_out,
	output logic pin_b_oe_n_out,
	output logic pin_b_level_out,
	output logic pad_rail_switch_en_out,
	output logic pad_supply_from_input_out,
	output freq_adjust_mode_t freq_adjust_mode_out,
	output logic [3:0] freq_adjust_pll_out,
	output logic [7:0] fuse_page_ptr_out,
	output logic fuse_ptr_legal_out,
	output logic io_supply_from_input_out
);

	if (NUM_PLL != 4 || DEBUG_W != 3) begin : g_check
		$error("bank is laid out for four plls and three debug taps");
	end

	logic [7:0] pll_en_reg;
	logic [7:0] mpio_reg;
	logic [7:0] spare_reg;
	logic [7:0] fuse_reg;
	logic [7:0] supply_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic rvalid_reg;
	logic pad_switch_reg;
	logic pad_input_reg;
	logic fuse_legal_reg;
	logic wr_pll;
	logic wr_mpio;
	logic wr_spare;
	logic wr_fuse;
	logic wr_supply;
	pin_feed_t feed_a;
	pin_feed_t feed_b;

	always_comb begin
		wr_pll = 1'b0;
		wr_mpio = 1'b0;
		wr_spare = 1'b0;
		wr_fuse = 1'b0;
		wr_supply = 1'b0;
		if (reg_req_in.addr == `ADDR_PLL_ENABLE) begin
			wr_pll = reg_req_in.wr;
		end else if (reg_req_in.addr == `ADDR_MPIO_CTRL) begin
			wr_mpio = reg_req_in.wr;
		end else if (reg_req_in.addr == `ADDR_FREQ_ADJ) begin
			wr_spare = reg_req_in.wr;
		end else if (reg_req_in.addr == `ADDR_FUSE_PTR) begin
			wr_fuse = reg_req_in.wr;
		end else if (reg_req_in.addr == `ADDR_IO_SUPPLY) begin
			wr_supply = reg_req_in.wr;
		end
	end

	// all eight bits are stored so that reads return what was written
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pll_en_reg <= `REG_RESET;
		end else if (wr_pll) begin
			pll_en_reg <= reg_req_in.wdata;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mpio_reg <= `REG_RESET;
		end else if (wr_mpio) begin
			mpio_reg <= reg_req_in.wdata;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			spare_reg <= `REG_RESET;
		end else if (wr_spare) begin
			spare_reg <= reg_req_in.wdata;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fuse_reg <= `REG_RESET;
		end else if (wr_fuse) begin
			fuse_reg <= reg_req_in.wdata;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			supply_reg <= `REG_RESET;
		end else if (wr_supply) begin
			supply_reg <= reg_req_in.wdata;
		end
	end

	// a read in the same cycle as a write sees the old contents
	always_comb begin
		if (reg_req_in.addr == `ADDR_PLL_ENABLE) begin
			rdata_next = pll_en_reg;
		end else if (reg_req_in.addr == `ADDR_MPIO_CTRL) begin
			rdata_next = mpio_reg;
		end else if (reg_req_in.addr == `ADDR_FREQ_ADJ) begin
			rdata_next = spare_reg;
		end else if (reg_req_in.addr == `ADDR_FUSE_PTR) begin
			rdata_next = fuse_reg;
		end else if (reg_req_in.addr == `ADDR_IO_SUPPLY) begin
			rdata_next = supply_reg;
		end else begin
			rdata_next = `RDATA_UNMAPPED;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_reg <= `REG_RESET;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= reg_req_in.rd;
			if (reg_req_in.rd) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	// pad ring: fixed rail follows the io supply select, else switch stays on
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pad_switch_reg <= 1'b1;
			pad_input_reg <= 1'b0;
		end else begin
			pad_switch_reg <= ~spare_reg[`PAD_FIXED_BIT];
			pad_input_reg <= spare_reg[`PAD_FIXED_BIT]
				& supply_reg[`IO_SUPPLY_BIT];
		end
	end

	// flags as legal a pointer that is one-hot and does not aim at the reserved page
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fuse_legal_reg <= 1'b0;
		end else begin
			fuse_legal_reg <= $onehot(fuse_reg)
				&& !fuse_reg[`FUSE_PAGE4_BIT];
		end
	end

	always_comb begin
		feed_a.all = (|notify_in.clk_loss) | (|notify_in.pll_lock_loss);
		feed_a.pll = |notify_in.pll_lock_loss;
		feed_a.clk = |notify_in.clk_loss;
		feed_a.monitor = notify_in.monitor;
		feed_a.debug = notify_in.debug;
		feed_b = feed_a;
		feed_b.pll = (|notify_in.pll_lock_loss)
			| (|notify_in.holdover_freeze);
	end

	mpio_pin_mux #(
		.DBG1_EN(1'b1)
	) u_pin_a (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.dir_out_in(mpio_reg[`PIN_A_DIR_BIT]),
		.sel_in(pin_src_t'(mpio_reg[`PIN_A_SEL_HI:`PIN_A_SEL_LO])),
		.feed_in(feed_a),
		.pin_in(pin_a_in),
		.pin_out(pin_a_out),
		.pin_oe_n_out(pin_a_oe_n_out),
		.pin_level_out(pin_a_level_out)
	);

	mpio_pin_mux #(
		.DBG1_EN(1'b0)
	) u_pin_b (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.dir_out_in(mpio_reg[`PIN_B_DIR_BIT]),
		.sel_in(pin_src_t'(mpio_reg[`PIN_B_SEL_HI:`PIN_B_SEL_LO])),
		.feed_in(feed_b),
		.pin_in(pin_b_in),
		.pin_out(pin_b_out),
		.pin_oe_n_out(pin_b_oe_n_out),
		.pin_level_out(pin_b_level_out)
	);

	assign reg_rdata_out = rdata_reg;
	assign reg_rdata_valid_out = rvalid_reg;
	assign pll_enable_n_out = pll_en_reg[`PLL_EN_HI:`PLL_EN_LO];
	assign pad_rail_switch_en_out = pad_switch_reg;
	assign pad_supply_from_input_out = pad_input_reg;
	assign freq_adjust_mode_out =
		freq_adjust_mode_t'(spare_reg[`FADJ_MODE_HI:`FADJ_MODE_LO]);
	assign freq_adjust_pll_out = spare_reg[`FADJ_PLL_HI:`FADJ_PLL_LO];
	assign fuse_page_ptr_out = fuse_reg;
	assign fuse_ptr_legal_out = fuse_legal_reg;
	assign io_supply_from_input_out = supply_reg[`IO_SUPPLY_BIT];

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence wr_spare_s;
		reg_req_in.wr && reg_req_in.addr == `ADDR_FREQ_ADJ;
	endsequence

	sequence wr_then_rd_s;
		wr_spare_s ##1 !reg_req_in.wr ##1 (reg_req_in.rd
			&& !reg_req_in.wr && reg_req_in.addr == `ADDR_FREQ_ADJ);
	endsequence

	pll_enable_a: assert property (
		(reg_req_in.wr && reg_req_in.addr == `ADDR_PLL_ENABLE)
		|=> pll_enable_n_out == $past(reg_req_in.wdata[3:0]))
		else $error("pll enables do not follow the write");

	pin_a_dir_a: assert property (
		(reg_req_in.wr && reg_req_in.addr == `ADDR_MPIO_CTRL)
		|=> ##1 pin_a_oe_n_out == !$past(reg_req_in.wdata[7], 2))
		else $error("first pin direction wrong two cycles after write");

	pin_a_src_a: assert property (
		(mpio_reg[7] && mpio_reg[6:4] == 3'h3)
		|=> pin_a_out == $past(|notify_in.clk_loss))
		else $error("first pin does not carry clock loss");

	pin_b_dir_a: assert property (
		!mpio_reg[3] |=> pin_b_oe_n_out)
		else $error("second pin driven while an input");

	pin_b_src_a: assert property (
		(mpio_reg[3] && mpio_reg[2:0] == 3'h2) |=> pin_b_out ==
		$past((|notify_in.pll_lock_loss) | (|notify_in.holdover_freeze)))
		else $error("second pin pll group wrong");

	pad_ring_a: assert property (
		spare_reg[7] |=> (!pad_rail_switch_en_out
		&& pad_supply_from_input_out == $past(supply_reg[7])))
		else $error("pad ring not following io supply select");

	freq_mode_a: assert property (
		wr_spare_s |=> freq_adjust_mode_out == $past(reg_req_in.wdata[5:4]))
		else $error("frequency adjust mode not updated");

	freq_pll_a: assert property (
		wr_spare_s |=> freq_adjust_pll_out == $past(reg_req_in.wdata[3:0]))
		else $error("frequency adjust pll not updated");

	fuse_ptr_a: assert property (
		(reg_req_in.wr && reg_req_in.addr == `ADDR_FUSE_PTR)
		|=> fuse_page_ptr_out == $past(reg_req_in.wdata))
		else $error("fuse pointer not updated");

	io_supply_a: assert property (
		(reg_req_in.wr && reg_req_in.addr == `ADDR_IO_SUPPLY)
		|=> io_supply_from_input_out == $past(reg_req_in.wdata[7]))
		else $error("io supply select not updated");

	readback_a: assert property (
		wr_then_rd_s |=> (reg_rdata_valid_out
		&& reg_rdata_out == $past(reg_req_in.wdata, 3)))
		else $error("read does not return last written value");

endmodule : clock_gen_config_regs

/* File: hdl/mpio_pin_mux.sv */
// one multipurpose pin: direction, source select and input synchroniser
`timescale 1ns/1ps

module mpio_pin_mux import clock_gen_pkg::*; #(
	parameter bit DBG1_EN = 1'b1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic dir_out_in,
	input wire pin_src_t sel_in,
	input wire pin_feed_t feed_in,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe_n_out,
	output logic pin_level_out
);

	logic sync1_reg;
	logic sync2_reg;
	logic drive_next;
	logic drive_reg;
	logic oe_n_reg;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= pin_in;
			sync2_reg <= sync1_reg;
		end
	end

	always_comb begin
		case (sel_in)
			PIN_SRC_ZERO: drive_next = 1'b0;
			PIN_SRC_ALL: drive_next = feed_in.all;
			PIN_SRC_PLL: drive_next = feed_in.pll;
			PIN_SRC_CLK: drive_next = feed_in.clk;
			PIN_SRC_MON: drive_next = feed_in.monitor;
			PIN_SRC_DBG0: drive_next = feed_in.debug[0];
			// a pin without this debug tap drives low on the code
			PIN_SRC_DBG1: drive_next = DBG1_EN & feed_in.debug[1];
			PIN_SRC_DBG2: drive_next = feed_in.debug[2];
			default: drive_next = 1'b0;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			drive_reg <= 1'b0;
			oe_n_reg <= 1'b1;
		end else begin
			// as an input the pin is released and driven value parks low
			drive_reg <= dir_out_in & drive_next;
			oe_n_reg <= ~dir_out_in;
		end
	end

	assign pin_out = drive_reg;
	assign pin_oe_n_out = oe_n_reg;
	assign pin_level_out = sync2_reg;

	pin_release_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		!dir_out_in |=> (pin_oe_n_out && !pin_out))
		else $error("pin not released while configured as input");

endmodule : mpio_pin_mux

/* File: include/clock_gen_cfg.svh */
// register offsets, field positions and reset values of the config bank
`ifndef CLOCK_GEN_CFG_SVH
`define CLOCK_GEN_CFG_SVH

`define ADDR_PLL_ENABLE 8'h10
`define ADDR_MPIO_CTRL 8'h18
`define ADDR_FREQ_ADJ 8'h19
`define ADDR_FUSE_PTR 8'h22
`define ADDR_IO_SUPPLY 8'h23

`define REG_RESET 8'h00
`define RDATA_UNMAPPED 8'h00

`define PLL_EN_HI 3
`define PLL_EN_LO 0

`define PIN_A_DIR_BIT 7
`define PIN_A_SEL_HI 6
`define PIN_A_SEL_LO 4
`define PIN_B_DIR_BIT 3
`define PIN_B_SEL_HI 2
`define PIN_B_SEL_LO 0

`define PAD_FIXED_BIT 7
`define FADJ_MODE_HI 5
`define FADJ_MODE_LO 4
`define FADJ_PLL_HI 3
`define FADJ_PLL_LO 0

`define FUSE_PAGE4_BIT 4
`define IO_SUPPLY_BIT 7

`endif

/* File: include/clock_gen_pkg.sv */
// types shared by the clock generator configuration bank
package clock_gen_pkg;

	typedef enum logic [1:0] {
		FADJ_DIGITAL = 2'h0,
		FADJ_DIV_LARGE = 2'h1,
		FADJ_DIV_SMALL = 2'h2,
		FADJ_UNDEFINED = 2'h3
	} freq_adjust_mode_t;

	typedef enum logic [2:0] {
		PIN_SRC_ZERO = 3'h0,
		PIN_SRC_ALL = 3'h1,
		PIN_SRC_PLL = 3'h2,
		PIN_SRC_CLK = 3'h3,
		PIN_SRC_MON = 3'h4,
		PIN_SRC_DBG0 = 3'h5,
		PIN_SRC_DBG1 = 3'h6,
		PIN_SRC_DBG2 = 3'h7
	} pin_src_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [3:0] clk_loss;
		logic [3:0] pll_lock_loss;
		logic [3:0] holdover_freeze;
		logic monitor;
		logic [2:0] debug;
	} notify_src_t;

	typedef struct packed {
		logic all;
		logic pll;
		logic clk;
		logic monitor;
		logic [2:0] debug;
	} pin_feed_t;

endpackage : clock_gen_pkg

/* File: tb/clock_gen_config_regs_tb.sv */
// self-checking bench for the clock generator configuration slice
`timescale 1ns/1ps
`include "clock_gen_cfg.svh"

module clock_gen_config_regs_tb import clock_gen_pkg::*; ();
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	reg_req_t req;
	notify_src_t notify = '0;
	logic ext_a = 1'b0;
	logic ext_b = 1'b0;
	logic pin_a_wire, pin_b_wire, a_o, a_oe_n, a_lvl, b_o, b_oe_n, b_lvl;
	logic [7:0] rdata, fuse_ptr;
	logic rvalid, sw_en, pad_in, fuse_ok, io_in;
	logic [3:0] pll_en_n, fadj_pll;
	freq_adjust_mode_t fadj_mode;
	int err_count = 0;
	int samples_checked = 0;
	logic [7:0] addrs [5] = '{`ADDR_PLL_ENABLE, `ADDR_MPIO_CTRL,
		`ADDR_FREQ_ADJ, `ADDR_FUSE_PTR, `ADDR_IO_SUPPLY};
	notify_src_t pat [2] = '{{4'h0, 4'h0, 4'h2, 1'b1, 3'h5},
		{4'h8, 4'h0, 4'h0, 1'b0, 3'h2}};

	always #12.5 clk_in = ~clk_in;

	// a pad that the block drives shows the driven level to its own input
	assign pin_a_wire = a_oe_n ? ext_a : a_o;
	assign pin_b_wire = b_oe_n ? ext_b : b_o;

	host_model host (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
		.req_out(req));

	clock_gen_config_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.reg_req_in(req), .notify_in(notify), .pin_a_in(pin_a_wire),
		.pin_b_in(pin_b_wire), .reg_rdata_out(rdata),
		.reg_rdata_valid_out(rvalid), .pll_enable_n_out(pll_en_n),
		.pin_a_out(a_o), .pin_a_oe_n_out(a_oe_n), .pin_a_level_out(a_lvl),
		.pin_b_out(b_o), .pin_b_oe_n_out(b_oe_n), .pin_b_level_out(b_lvl),
		.pad_rail_switch_en_out(sw_en), .pad_supply_from_input_out(pad_in),
		.freq_adjust_mode_out(fadj_mode), .freq_adjust_pll_out(fadj_pll),
		.fuse_page_ptr_out(fuse_ptr), .fuse_ptr_legal_out(fuse_ok),
		.io_supply_from_input_out(io_in));

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim

	task automatic check_val(input string what, input logic [7:0] exp,
			input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check_val

	task automatic check_read(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		host.read_reg(addr, d, ok);
		check_val("read valid", 8'h01, {7'h00, ok});
		check_val("read data", exp, d);
	endtask : check_read

	task automatic settle;
		repeat (3) @(negedge clk_in);
	endtask : settle

	function automatic logic exp_a(input logic [2:0] s, input notify_src_t n);
		case (s)
			3'h0: return 1'b0;
			3'h1: return |{n.clk_loss, n.pll_lock_loss};
			3'h2: return |n.pll_lock_loss;
			3'h3: return |n.clk_loss;
			3'h4: return n.monitor;
			default: return n.debug[s - 3'h5];
		endcase
	endfunction : exp_a

	// pin b differs from pin a in its pll group and in having no 110 debug
	function automatic logic exp_b(input logic [2:0] s, input notify_src_t n);
		if (s == 3'h2) return |{n.pll_lock_loss, n.holdover_freeze};
		if (s == 3'h6) return 1'b0;
		return exp_a(s, n);
	endfunction : exp_b

	task automatic do_reset;
		@(negedge clk_in);
		rst_n_in = 1'b0;
		repeat (20) @(negedge clk_in);
		rst_n_in = 1'b1;
	endtask : do_reset

	task automatic t_reset;
		check_val("pll_en_n", 8'h00, {4'h0, pll_en_n});
		check_val("a_oe_n", 8'h01, {7'h00, a_oe_n});
		check_val("b_oe_n", 8'h01, {7'h00, b_oe_n});
		check_val("sw_en", 8'h01, {7'h00, sw_en});
		check_val("io_in", 8'h00, {7'h00, io_in});
		for (int i = 0; i < 5; i++) check_read(addrs[i], `REG_RESET);
	endtask : t_reset

	task automatic t_pll;
		logic [7:0] v [3] = '{8'h05, 8'h0a, 8'hf7};
		for (int i = 0; i < 3; i++) begin
			host.write_reg(`ADDR_PLL_ENABLE, v[i]);
			settle();
			check_val("pll_en_n", {4'h0, v[i][3:0]}, {4'h0, pll_en_n});
			check_read(`ADDR_PLL_ENABLE, v[i]);
		end
	endtask : t_pll

	task automatic t_pins;
		for (int s = 0; s < 8; s++) begin
			for (int p = 0; p < 2; p++) begin
				notify = pat[p];
				host.write_reg(`ADDR_MPIO_CTRL, {1'b1, 3'(s), 1'b1, 3'(s)});
				settle();
				check_val("a_out", {7'h00, exp_a(3'(s), pat[p])}, {7'h00, a_o});
				check_val("b_out", {7'h00, exp_b(3'(s), pat[p])}, {7'h00, b_o});
				check_val("a_oe_n", 8'h00, {7'h00, a_oe_n});
				check_val("b_oe_n", 8'h00, {7'h00, b_oe_n});
			end
		end
	endtask : t_pins

	task automatic t_pin_in;
		// inputs with live selects, so a leaking drive would show as a one
		host.write_reg(`ADDR_MPIO_CTRL, 8'h61);
		for (int v = 0; v < 2; v++) begin
			ext_a = 1'(v);
			ext_b = ~1'(v);
			settle();
			check_val("a_lvl", 8'(v), {7'h00, a_lvl});
			check_val("b_lvl", 8'(1 - v), {7'h00, b_lvl});
			check_val("a_oe_n", 8'h01, {7'h00, a_oe_n});
			check_val("b_out", 8'h00, {7'h00, b_o});
			check_val("a_out", 8'h00, {7'h00, a_o});
		end
		// direction bits are independent of each other
		host.write_reg(`ADDR_MPIO_CTRL, 8'h08);
		settle();
		check_val("a_oe_n", 8'h01, {7'h00, a_oe_n});
		check_val("b_oe_n", 8'h00, {7'h00, b_oe_n});
	endtask : t_pin_in

	task automatic t_spare;
		for (int m = 0; m < 3; m++) begin
			host.write_reg(`ADDR_FREQ_ADJ, {2'h0, 2'(m), 4'h1 << m});
			settle();
			check_val("fadj_mode", 8'(m), {6'h00, fadj_mode});
			check_val("fadj_pll", 8'h01 << m, {4'h0, fadj_pll});
			check_val("sw_en", 8'h01, {7'h00, sw_en});
		end
		host.write_reg(`ADDR_IO_SUPPLY, 8'h80);
		host.write_reg(`ADDR_FREQ_ADJ, 8'h80);
		settle();
		check_val("io_in", 8'h01, {7'h00, io_in});
		check_val("sw_en", 8'h00, {7'h00, sw_en});
		check_val("pad_in", 8'h01, {7'h00, pad_in});
		host.write_reg(`ADDR_IO_SUPPLY, 8'h00);
		settle();
		check_val("pad_in", 8'h00, {7'h00, pad_in});
		check_read(`ADDR_FREQ_ADJ, 8'h80);
		// read two cycles after the write, the spacing the readback check uses
		host.write_reg(`ADDR_FREQ_ADJ, 8'h25);
		check_read(`ADDR_FREQ_ADJ, 8'h25);
	endtask : t_spare

	task automatic t_fuse;
		for (int b = 0; b < 8; b++) begin
			if (b != 4) begin
				host.write_reg(`ADDR_FUSE_PTR, 8'h01 << b);
				settle();
				check_val("fuse_ptr", 8'h01 << b, fuse_ptr);
				check_val("fuse_ok", 8'h01, {7'h00, fuse_ok});
			end
		end
		host.write_reg(`ADDR_FUSE_PTR, 8'h41);
		settle();
		check_val("fuse_ok", 8'h00, {7'h00, fuse_ok});
	endtask : t_fuse

	task automatic t_unmapped;
		host.write_reg(8'h11, 8'hff);
		check_read(8'h11, `RDATA_UNMAPPED);
		check_read(`ADDR_PLL_ENABLE, 8'hf7);
	endtask : t_unmapped

	initial begin
		// generous bound: the sequence needs well under a thousand cycles
		repeat (8000) @(posedge clk_in);
		err_count++;
		end_sim();
	end

	initial begin
		repeat (20) @(negedge clk_in);
		rst_n_in = 1'b1;
		t_reset();
		t_pll();
		t_pins();
		t_pin_in();
		t_spare();
		t_fuse();
		t_unmapped();
		do_reset();
		t_reset();
		end_sim();
	end
endmodule : clock_gen_config_regs_tb

/* File: tb/host_model.sv */
// host side of the register port: byte writes and reads, one at a time
`timescale 1ns/1ps
`include "clock_gen_cfg.svh"

module host_model import clock_gen_pkg::*; (
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	input wire logic rvalid_in,
	output reg_req_t req_out
);
	initial req_out = '0;

	// requests change only at the falling edge, one cycle apart
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge clk_in);
		req_out.wr = 1'b1;
		req_out.addr = addr;
		// page 4 is reserved, so the host never points at it
		req_out.wdata = (addr == `ADDR_FUSE_PTR) ? (data & 8'hef) : data;
		@(negedge clk_in);
		req_out.wr = 1'b0;
		req_out.wdata = ~req_out.wdata;
	endtask : write_reg

	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
			output logic got);
		got = 1'b0;
		data = 8'h00;
		@(negedge clk_in);
		req_out.rd = 1'b1;
		req_out.addr = addr;
		@(negedge clk_in);
		req_out.rd = 1'b0;
		// valid is a single-cycle pulse, so look at every cycle
		for (int i = 0; i < 3 && got !== 1'b1; i++) begin
			if (rvalid_in === 1'b1) begin
				got = 1'b1;
				data = rdata_in;
			end else begin
				@(negedge clk_in);
			end
		end
	endtask : read_reg
endmodule : host_model
